// ==== hw/hvl_cfg.svh ====
// constants for the high-voltage step and lock command decoder
`ifndef HVL_CFG_SVH
`define HVL_CFG_SVH

// ==========================================================
// memory addresses
`define HVL_ADDR_WIPER0 4'h0
`define HVL_ADDR_WIPER1 4'h1
`define HVL_ADDR_LOCK0 4'h2
`define HVL_ADDR_LOCK1 4'h3
`define HVL_ADDR_TERMINAL_CONTROL_REGISTER 4'h4
`define HVL_ADDR_STATUS 4'h5
`define HVL_ADDR_RSV_HI 4'hE
`define HVL_ADDR_PROTECT 4'hF

// ==========================================================
// command codes and byte layout
`define HVL_CMD_INC 2'h1
`define HVL_CMD_DEC 2'h2
`define HVL_BYTE_LAST 3'h7
`define HVL_ERR_BIT 3'h5

// ==========================================================
// reset values and wiper range
`define HVL_WIPER_RST 9'h080
`define HVL_WIPER_FS 9'h100

// ==========================================================
// timing
`define HVL_SYS_MHZ 20
`define HVL_NV_WC_US 5000
`define HVL_NV_WC_CYCLES (`HVL_NV_WC_US * `HVL_SYS_MHZ)

`endif

// ==== hw/hvl_link.sv ====
// serial-clock side: shifts command bytes and drives the error low
`timescale 1ns/10ps
`include "hvl_cfg.svh"

module hvl_link
	import hvl_pkg::*;
(
	input wire logic sck,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic hv_cs,
	output logic [7:0] cmd_byte,
	output logic cmd_hv,
	output logic cmd_tog,
	output logic cs_rel_tog,
	output logic sdo_oe
);
	hvl_link_s lq;
	hvl_link_s ld;
	hvl_frame_s fq;
	hvl_frame_s fd;
	logic [5:0] head;
	logic rel_q;

	// ==========================================================
	// byte assembly
	always_comb
	begin
		ld = lq;
		fd = fq;
		head = {lq.shift[4:0], sdi};
		ld.shift = {lq.shift[5:0], sdi};
		fd.cnt = fq.cnt + 3'h1;
		if (fq.cnt == `HVL_BYTE_LAST)
		begin
			ld.cbyte = {lq.shift, sdi};
			ld.hv = hv_cs;
			ld.tog = ~lq.tog;
		end
		// error known once address and command bits are in
		if (fq.cnt == `HVL_ERR_BIT && hvl_invalid(head[5:2], head[1:0], hv_cs))
			fd.err = 1'b1; // R11
	end

	// sck stops between frames, so reset cannot wait for an edge
	always_ff @(posedge sck or posedge rst)
	begin
		if (rst)
			lq <= '0;
		else
			lq <= ld;
	end

	// raising chip select clears the frame at once, no idle gap
	always_ff @(posedge sck or posedge cs_n or posedge rst)
	begin
		if (cs_n || rst)
			fq <= '0; // R2 R11
		else
			fq <= fd;
	end

	// release kept as a toggle so a pulse shorter than sys_clk survives
	always_ff @(posedge cs_n or posedge rst)
	begin
		if (rst)
			rel_q <= 1'b0;
		else
			rel_q <= ~rel_q; // R1 R2
	end

	assign cmd_byte = lq.cbyte;
	assign cmd_hv = lq.hv;
	assign cmd_tog = lq.tog;
	assign sdo_oe = fq.err;
	assign cs_rel_tog = rel_q;

	// ==========================================================
	// checks
	property p_err_hold;
		@(posedge sck) disable iff (cs_n)
		(fq.cnt == `HVL_ERR_BIT && hvl_invalid(head[5:2], head[1:0], hv_cs))
		|=> sdo_oe [*2];
	endproperty
	a_err_hold: assert property (p_err_hold) // R11
		else $error("sdo not held low after command error");
endmodule

// ==== hw/hvl_pkg.sv ====
// types and shared decode for the high-voltage command decoder
`include "hvl_cfg.svh"

package hvl_pkg;

	// ==========================================================
	// nonvolatile write sequencing
	typedef enum logic [1:0] {NV_IDLE, NV_ARMED, NV_WRITE} hvl_nv_e;

	// ==========================================================
	// link-side state
	typedef struct packed {
		logic [6:0] shift;
		logic [7:0] cbyte;
		logic hv;
		logic tog;
	} hvl_link_s;

	typedef struct packed {
		logic [2:0] cnt;
		logic err;
	} hvl_frame_s;

	// ==========================================================
	// decode
	function automatic logic hvl_is_step(input logic [1:0] cmd);
		hvl_is_step = (cmd == `HVL_CMD_INC) || (cmd == `HVL_CMD_DEC);
	endfunction

	function automatic logic hvl_volatile(input logic [3:0] addr);
		hvl_volatile = (addr == `HVL_ADDR_WIPER0) ||
			(addr == `HVL_ADDR_WIPER1) || (addr == `HVL_ADDR_TERMINAL_CONTROL_REGISTER) ||
			(addr == `HVL_ADDR_STATUS);
	endfunction

	// nonvolatile bits move only with high voltage on chip select
	function automatic logic hvl_invalid(input logic [3:0] addr,
		input logic [1:0] cmd, input logic hv);
		logic nvbit;
		nvbit = (addr == `HVL_ADDR_LOCK0) || (addr == `HVL_ADDR_LOCK1) ||
			(addr == `HVL_ADDR_PROTECT);
		hvl_invalid = hvl_is_step(cmd) &&
			((addr >= `HVL_ADDR_TERMINAL_CONTROL_REGISTER && addr <= `HVL_ADDR_RSV_HI) ||
			(nvbit && !hv));
	endfunction

endpackage

// ==== hw/hvl_sync.sv ====
// two-flop level synchroniser into the system clock
`timescale 1ns/10ps

module hvl_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hvl_sync_s;

	hvl_sync_s st_q;
	hvl_sync_s st_d;

	// ==========================================================
	// first stage feeds only the second
	always_comb
	begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			st_q <= {RST_VAL, RST_VAL};
		else
			st_q <= st_d;
	end

	assign q = st_q.s2;
endmodule

// ==== hw/hvl_top.sv ====
// high-voltage step, lock and protect command decoder
`timescale 1ns/10ps
`include "hvl_cfg.svh"

// Functional notes
// R1 - nonvolatile write starts only after a whole byte and chip select rises
// R2 - chip select may go active again at once; no idle gap enforced
// R3 - during a write cycle only addresses 0, 1, 4 and 5 are accepted
// R4 - a flag shows whether a nonvolatile write cycle is running
// R5 - step at address 0 moves wiper 0 down or up by one
// R6 - step at address 1 moves wiper 1 down or up by one
// R7 - decrement sets, increment clears lock 0, lock 1 or write protect
// R8 - step at address 4 leaves terminal control alone, raises command error
// R9 - steps to 4 and 5 to E are invalid and change nothing
// R10 - lock and protect changes are high-voltage steps to 2, 3 and F
// R11 - after an error serial output stays low until chip select rises
// R12 - write flag set at start, cleared when the cycle time elapses
module hvl_top
	import hvl_pkg::*;
#(
	parameter int WIPER_W = 9,
	parameter int NV_WC_CYCLES = `HVL_NV_WC_CYCLES,
	parameter int TMR_W = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic hv_cs,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	output logic [WIPER_W-1:0] wiper0_value,
	output logic [WIPER_W-1:0] wiper1_value,
	output logic wiper0_lock_bit,
	output logic wiper1_lock_bit,
	output logic sw_protect_bit,
	output logic nv_write_active_flag,
	output logic command_error_flag
);
	localparam logic [WIPER_W-1:0] FS = WIPER_W'(`HVL_WIPER_FS);
	localparam logic [WIPER_W-1:0] MID = WIPER_W'(`HVL_WIPER_RST);
	localparam logic [TMR_W-1:0] WC_LAST = TMR_W'(NV_WC_CYCLES - 1);

	typedef struct packed {
		logic seen;
		logic csd;
		logic [WIPER_W-1:0] w0;
		logic [WIPER_W-1:0] w1;
		logic lk0;
		logic lk1;
		logic wp;
		logic err;
		hvl_nv_e nv;
		logic [3:0] tgt;
		logic val;
		logic [TMR_W-1:0] tmr;
	} hvl_top_s;

	hvl_top_s q;
	hvl_top_s d;

	logic [7:0] cmd_byte;
	logic cmd_hv;
	logic cmd_tog;
	logic cs_rel_tog;
	logic tog_s;
	logic cs_s;
	logic [3:0] addr;
	logic [1:0] cmd;
	logic new_cmd;
	logic cs_rise;
	logic busy;
	logic gated;
	logic bad;
	logic acc;
	logic dec;

	// ==========================================================
	// wiper stepping with end stops
	function automatic logic [WIPER_W-1:0] step_wiper(
		input logic [WIPER_W-1:0] w, input logic down);
		step_wiper = w;
		// above full scale stepping is disabled both ways
		if (down && w != '0 && w <= FS)
			step_wiper = w - WIPER_W'(1);
		else if (!down && w < FS)
			step_wiper = w + WIPER_W'(1);
	endfunction

	// ==========================================================
	// serial clock domain and crossings
	hvl_link u_link (
		.sck(sck),
		.rst(rst),
		.cs_n(cs_n),
		.sdi(sdi),
		.hv_cs(hv_cs),
		.cmd_byte(cmd_byte),
		.cmd_hv(cmd_hv),
		.cmd_tog(cmd_tog),
		.cs_rel_tog(cs_rel_tog),
		.sdo_oe(sdo_oe)
	);

	// byte is held for a whole byte time, longer than the toggle sync
	hvl_sync #(.W(1), .RST_VAL(1'b0)) u_sync_tog (
		.sys_clk(sys_clk),
		.rst(rst),
		.d(cmd_tog),
		.q(tog_s)
	);

	// release toggle, not the level: a short high pulse is not lost
	hvl_sync #(.W(1), .RST_VAL(1'b0)) u_sync_cs (
		.sys_clk(sys_clk),
		.rst(rst),
		.d(cs_rel_tog),
		.q(cs_s)
	);

	// ==========================================================
	// decode of a received byte
	always_comb
	begin
		addr = cmd_byte[7:4];
		cmd = cmd_byte[3:2];
		dec = (cmd == `HVL_CMD_DEC);
		new_cmd = (tog_s != q.seen) && hvl_is_step(cmd);
		cs_rise = (cs_s != q.csd); // R1 R2
		busy = (q.nv == NV_WRITE);
		gated = busy && !hvl_volatile(addr); // R3
		bad = hvl_invalid(addr, cmd, cmd_hv); // R8 R9
		acc = new_cmd && !gated && !bad;
	end

	// ==========================================================
	// command execution and write sequencing
	always_comb
	begin
		d = q;
		d.seen = tog_s;
		d.csd = cs_s;
		// chip select release clears the error; a new error wins below
		if (cs_rise)
			d.err = 1'b0; // R11
		if (new_cmd && !gated && bad)
			d.err = 1'b1; // R8 R9
		if (acc)
		begin
			case (addr)
				`HVL_ADDR_WIPER0: d.w0 = step_wiper(q.w0, dec); // R5
				`HVL_ADDR_WIPER1: d.w1 = step_wiper(q.w1, dec); // R6
				`HVL_ADDR_LOCK0,
				`HVL_ADDR_LOCK1,
				`HVL_ADDR_PROTECT:
				begin
					d.tgt = addr; // R10
					d.val = dec;
					d.nv = NV_ARMED;
				end
				default: d.nv = q.nv;
			endcase
		end
		case (q.nv)
			NV_IDLE: d.tmr = '0;
			NV_ARMED:
			begin
				if (cs_rise)
				begin
					d.nv = NV_WRITE; // R1 R12
					d.tmr = WC_LAST;
				end
			end
			NV_WRITE:
			begin
				if (q.tmr == '0)
				begin
					d.nv = NV_IDLE; // R12
					case (q.tgt)
						`HVL_ADDR_LOCK0: d.lk0 = q.val; // R7
						`HVL_ADDR_LOCK1: d.lk1 = q.val; // R7
						default: d.wp = q.val; // R7
					endcase
				end
				else
					d.tmr = q.tmr - TMR_W'(1);
			end
			default: d.nv = NV_IDLE;
		endcase
		// arming and release seen in the same cycle still start
		if (q.nv == NV_IDLE && d.nv == NV_ARMED && cs_rise)
		begin
			d.nv = NV_WRITE; // R1
			d.tmr = WC_LAST;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.w0 <= MID;
			q.w1 <= MID;
		end
		else
			q <= d;
	end

	// ==========================================================
	// outputs
	assign sdo_o = 1'b0;
	assign wiper0_value = q.w0;
	assign wiper1_value = q.w1;
	assign wiper0_lock_bit = q.lk0;
	assign wiper1_lock_bit = q.lk1;
	assign sw_protect_bit = q.wp;
	assign nv_write_active_flag = (q.nv == NV_WRITE); // R4
	assign command_error_flag = q.err;

	// ==========================================================
	// checks
	logic [TMR_W:0] hc_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst || !nv_write_active_flag)
			hc_q <= '0;
		else
			hc_q <= hc_q + (TMR_W+1)'(1);
	end

	property p_start_on_cs;
		@(posedge sys_clk) disable iff (rst)
		(q.nv == NV_ARMED && cs_rise) |=> nv_write_active_flag;
	endproperty
	a_start_on_cs: assert property (p_start_on_cs) // R1
		else $error("write did not start on chip select release");

	property p_start_cause;
		@(posedge sys_clk) disable iff (rst)
		$rose(nv_write_active_flag) |-> $past(cs_rise);
	endproperty
	a_start_cause: assert property (p_start_cause) // R1
		else $error("write started without chip select release");

	property p_busy_gate;
		@(posedge sys_clk) disable iff (rst)
		(new_cmd && busy && q.tmr != '0 && !hvl_volatile(addr)) |=>
		$stable({q.w0, q.w1, q.lk0, q.lk1, q.wp, q.tgt});
	endproperty
	a_busy_gate: assert property (p_busy_gate) // R3
		else $error("command acted on during write cycle");

	property p_cycle_len;
		@(posedge sys_clk) disable iff (rst)
		$fell(nv_write_active_flag) |-> $past(hc_q) ==
			(TMR_W+1)'(NV_WC_CYCLES - 1);
	endproperty
	a_cycle_len: assert property (p_cycle_len) // R4 R12
		else $error("write cycle length wrong");

	property p_w0_dec;
		@(posedge sys_clk) disable iff (rst)
		(acc && addr == `HVL_ADDR_WIPER0 && dec && q.w0 != '0 && q.w0 <= FS)
		|=> q.w0 == $past(q.w0) - WIPER_W'(1);
	endproperty
	a_w0_dec: assert property (p_w0_dec) // R5
		else $error("wiper 0 did not step down");

	property p_w1_inc;
		@(posedge sys_clk) disable iff (rst)
		(acc && addr == `HVL_ADDR_WIPER1 && !dec && q.w1 < FS)
		|=> q.w1 == $past(q.w1) + WIPER_W'(1);
	endproperty
	a_w1_inc: assert property (p_w1_inc) // R6
		else $error("wiper 1 did not step up");

	sequence s_lock0_done;
		busy && q.tmr == '0 && q.tgt == `HVL_ADDR_LOCK0;
	endsequence

	property p_lock0;
		@(posedge sys_clk) disable iff (rst)
		s_lock0_done |=> wiper0_lock_bit == $past(q.val) ##1
			$stable(wiper0_lock_bit);
	endproperty
	a_lock0: assert property (p_lock0) // R7
		else $error("lock 0 not updated at end of write");

	property p_bad_cmd;
		@(posedge sys_clk) disable iff (rst)
		(new_cmd && !gated && bad) |=> command_error_flag &&
			$stable({q.w0, q.w1, q.tgt, q.val});
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) // R8 R9
		else $error("invalid step not flagged or changed state");
endmodule

// ==== tb/hvl_host.sv ====
// host model that drives the serial command link
`timescale 1ns/10ps

module hvl_host (
	output logic sck,
	output logic cs_n,
	output logic sdi,
	output logic hv_cs
);
	// ==========================================================
	// idle: clock parked low, data at its pull-up level
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b1;
		hv_cs = 1'b0;
	end

	// ==========================================================
	// framing; may follow a close with no idle gap
	task automatic frame_open(input logic hv);
		cs_n = 1'b0;
		hv_cs = hv;
		#15;
	endtask

	task automatic frame_close();
		cs_n = 1'b1;
		hv_cs = 1'b0;
		sdi = 1'b1;
		#15;
	endtask

	// ==========================================================
	// one byte, msb first, data set up a half period before rise
	task automatic put_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			sdi = b[i];
			#15 sck = 1'b1;
			#15 sck = 1'b0;
		end
	endtask
endmodule

// ==== tb/hvl_top_tb.sv ====
// self-checking bench for the high-voltage command decoder
`timescale 1ns/10ps
`include "hvl_cfg.svh"

module hvl_top_tb;
	logic sys_clk;
	logic rst = 1'b0;
	logic sck;
	logic cs_n;
	logic sdi;
	logic hv_cs;
	logic sdo_o;
	logic sdo_oe;
	logic [8:0] wiper0_value;
	logic [8:0] wiper1_value;
	logic wiper0_lock_bit;
	logic wiper1_lock_bit;
	logic sw_protect_bit;
	logic nv_write_active_flag;
	logic command_error_flag;
	logic [8:0] bits_w;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc_count = 0;
	logic [3:0] nv_addr [3] = '{4'h2, 4'h3, 4'hF};

	assign bits_w = {6'h00, sw_protect_bit, wiper1_lock_bit, wiper0_lock_bit};

	// short write cycle so the run stays brief
	hvl_top #(.NV_WC_CYCLES(60)) u_dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.sck(sck),
		.cs_n(cs_n),
		.hv_cs(hv_cs),
		.sdi(sdi),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.wiper0_value(wiper0_value),
		.wiper1_value(wiper1_value),
		.wiper0_lock_bit(wiper0_lock_bit),
		.wiper1_lock_bit(wiper1_lock_bit),
		.sw_protect_bit(sw_protect_bit),
		.nv_write_active_flag(nv_write_active_flag),
		.command_error_flag(command_error_flag)
	);

	hvl_host u_host (
		.sck(sck),
		.cs_n(cs_n),
		.sdi(sdi),
		.hv_cs(hv_cs)
	);

	// ==========================================================
	// clock, timeout and verdict
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 3000)
		begin
			mismatches++;
			summarize();
		end
	end

	// ==========================================================
	// helpers; sampling on the falling edge keeps clear of updates
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic wait_flag(input logic v, input int lim);
		int n;
		n = 0;
		while (nv_write_active_flag !== v && n < lim)
		begin
			@(negedge sys_clk);
			n++;
		end
		check(9'(nv_write_active_flag), 9'(v));
	endtask

	// opens a frame and sends n bytes, first byte in the top bits
	task automatic xfer(input logic hv, input logic [23:0] b, input int n);
		logic [23:0] w;
		w = b;
		u_host.frame_open(hv);
		for (int i = 0; i < n; i++)
		begin
			u_host.put_byte(w[23:16]);
			w = w << 8;
		end
	endtask

	task automatic nv_cmd(input logic [3:0] a, input logic [1:0] c);
		xfer(1'b1, {a, c, 2'h0, 16'h0000}, 1);
		cyc(6);
		check(9'(nv_write_active_flag), 9'h000);
		u_host.frame_close();
		// reopen at once: the short release must still start the write
		xfer(1'b0, 24'h000000, 0);
		wait_flag(1'b1, 10);
		u_host.frame_close();
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		check(wiper0_value, 9'h080);
		check(wiper1_value, 9'h080);
		check(bits_w, 9'h000);
		check(9'(nv_write_active_flag), 9'h000);
	endtask

	task automatic t_step();
		xfer(1'b0, 24'h081414, 3);
		u_host.frame_close();
		xfer(1'b0, 24'h180000, 1);
		u_host.frame_close();
		cyc(6);
		check(wiper0_value, 9'h07F);
		check(wiper1_value, 9'h081);
		check(9'(command_error_flag), 9'h000);
	endtask

	task automatic t_lock();
		logic [8:0] exp;
		exp = 9'h000;
		for (int i = 0; i < 3; i++)
		begin
			nv_cmd(nv_addr[i], `HVL_CMD_DEC);
			check(bits_w, exp);
			exp[i] = 1'b1;
			wait_flag(1'b0, 80);
			check(bits_w, exp);
		end
	endtask

	// lock 0 cleared while a step to wiper 0 and a lock 1 clear arrive
	task automatic t_busy();
		nv_cmd(4'h2, `HVL_CMD_INC);
		xfer(1'b1, 24'h083400, 2);
		u_host.frame_close();
		cyc(6);
		check(wiper0_value, 9'h07E);
		check(9'(nv_write_active_flag), 9'h001);
		wait_flag(1'b0, 80);
		check(bits_w, 9'h006);
		cyc(10);
		check(9'(nv_write_active_flag), 9'h000);
	endtask

	task automatic t_err();
		logic [3:0] a;
		// 2, 3 and F without high voltage are errors as well
		for (int i = 2; i < 16; i++)
		begin
			a = 4'(i);
			xfer(1'b0, {a, (a[0] ? `HVL_CMD_INC : `HVL_CMD_DEC),
				18'h00000}, 1);
			cyc(6);
			check(9'(command_error_flag), 9'h001);
			check(9'(sdo_oe), 9'h001);
			check(9'(sdo_o), 9'h000);
			u_host.frame_close();
			#1;
			check(9'(sdo_oe), 9'h000);
			cyc(6);
			check(9'(command_error_flag), 9'h000);
			check(wiper0_value, 9'h07E);
			check(bits_w, 9'h006);
		end
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		cyc(2);
		t_reset();
		t_step();
		t_lock();
		t_busy();
		t_err();
		summarize();
	end
endmodule
